// *** design/bie_regs.svh ***
`ifndef BIE_REGS_SVH
`define BIE_REGS_SVH

`define BIE_PC_W 9
`define BIE_PC_MSB 8
`define BIE_SWI_VECTOR 9'h001
`define BIE_PC_STEP 9'h001
`define BIE_REG_STEP 8'h01
`define BIE_ZERO_BYTE 8'h00
`define BIE_IRQ_EN_RESET 1'b0
`define BIE_IRQ_OFF 1'b0
`define BIE_IRQ_ON 1'b1
`define BIE_PULSE_OFF 1'b0
`define BIE_PC_RESET 9'h000
`define BIE_CYC_BRANCH 2'h2
`define BIE_CYC_SWI 2'h3
`define BIE_CYC_ONE 2'h1
`define BIE_CYC_NONE 2'h0
`define BIE_DEST_ACCUM 1'b0

`endif

// *** design/bie_pkg.sv ***
package bie_pkg;
  `include "bie_regs.svh"

  typedef enum logic [2:0] {
    BIE_OP_NONE = 3'b000,
    BIE_OP_IRQ_OFF = 3'b001,
    BIE_OP_IRQ_ON  = 3'b010,
    BIE_OP_JMP  = 3'b011,
    BIE_OP_JMPA = 3'b100,
    BIE_OP_INC  = 3'b101,
    BIE_OP_SWI  = 3'b110
  } bie_op_t;

  typedef struct packed {
    bie_op_t op;
    logic [8:0] addr;
    logic dest;
    logic [7:0] reg_val;
  } bie_instr_t;

  typedef struct packed {
    logic [7:0] accumulator;
    logic [7:0] page_high_buffer;
    logic [7:0] table_high_pointer;
  } bie_ctx_t;

  typedef struct packed {
    logic accum_we;
    logic reg_we;
    logic [7:0] data;
    logic zero_we;
    logic zero;
  } bie_wb_t;
endpackage : bie_pkg

// *** design/bie_register_increment_instr.sv ***
`timescale 1ns/1ps
module bie_register_increment_instr
  import bie_pkg::*;
(
  input wire logic [7:0] reg_val_i,
  input wire logic dest_i,
  output logic accum_we_o,
  output logic reg_we_o,
  output logic [7:0] sum_o,
  output logic zero_o
);
  // wraps naturally at 8 bits, so 0xff gives 0x00 with zero set
  assign sum_o = reg_val_i + `BIE_REG_STEP;
  assign zero_o = (sum_o == `BIE_ZERO_BYTE);
  assign accum_we_o = (dest_i == `BIE_DEST_ACCUM);
  assign reg_we_o = (dest_i != `BIE_DEST_ACCUM);
endmodule : bie_register_increment_instr

// *** design/bie_exec.sv ***
`timescale 1ns/1ps
module bie_exec
  import bie_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire bie_instr_t instr_i,
  input wire bie_ctx_t ctx_i,
  input wire logic [8:0] instr_pc_i,
  output logic instr_ready_o,
  output logic global_irq_enable_o,
  output logic pc_load_o,
  output logic [8:0] pc_o,
  output logic stack_push_o,
  output logic [8:0] stack_data_o,
  output bie_wb_t wb_o,
  output logic busy_o
);
  typedef enum logic [1:0] {
    BIE_ST_IDLE = 2'b00,
    BIE_ST_WAIT = 2'b01
  } bie_state_t;

  // sequencer: a multi-cycle op parks in wait while cyc_left runs down
  bie_state_t state;
  bie_state_t next_state;
  logic [1:0] cyc_left;
  logic [1:0] next_cyc_left;

  // every output below is a flop with its own next value
  logic global_irq_enable;
  logic next_global_irq_enable;
  logic pc_load;
  logic next_pc_load;
  logic [8:0] pc;
  logic [8:0] next_pc;
  logic stack_push;
  logic next_stack_push;
  logic [8:0] stack_data;
  logic [8:0] next_stack_data;
  bie_wb_t wb;
  bie_wb_t next_wb;

  // both branch kinds build the new pc from a page bit and a low byte
  function automatic logic [8:0] bie_page_join(input logic hi, input logic [7:0] lo);
    bie_page_join = {hi, lo};
  endfunction : bie_page_join

  // one opcode compare, shared by all six decode lines
  function automatic logic bie_op_is(input bie_op_t seen, input bie_op_t want);
    bie_op_is = (seen == want);
  endfunction : bie_op_is

  // cycle counts are totals; the take cycle is already spent when the count loads
  function automatic logic [1:0] bie_less_one(input logic [1:0] n);
    bie_less_one = n - `BIE_CYC_ONE;
  endfunction : bie_less_one

  // instructions offered while waiting are not taken; the fetch side must hold them
  wire idle = (state == BIE_ST_IDLE);
  wire take = instr_valid_i && idle;
  wire is_irq_off = take && bie_op_is(instr_i.op, BIE_OP_IRQ_OFF);
  wire is_irq_on = take && bie_op_is(instr_i.op, BIE_OP_IRQ_ON);
  wire is_jmp = take && bie_op_is(instr_i.op, BIE_OP_JMP);
  wire is_jmpa = take && bie_op_is(instr_i.op, BIE_OP_JMPA);
  wire is_inc = take && bie_op_is(instr_i.op, BIE_OP_INC);
  wire is_swi = take && bie_op_is(instr_i.op, BIE_OP_SWI);
  wire is_branch = is_jmp || is_jmpa;
  wire is_pc_change = is_branch || is_swi;

  // page bit comes from the buffer, so the top address bit is overridden
  wire [8:0] jmp_target = bie_page_join(ctx_i.page_high_buffer[0], instr_i.addr[7:0]);
  wire [8:0] jmpa_target = bie_page_join(ctx_i.table_high_pointer[0], ctx_i.accumulator);
  // return address wraps at the top of the 9-bit space rather than growing a bit
  wire [8:0] ret_addr = instr_pc_i + `BIE_PC_STEP;

  // wait lengths after the take cycle
  wire [1:0] branch_wait = bie_less_one(`BIE_CYC_BRANCH);
  wire [1:0] swi_wait = bie_less_one(`BIE_CYC_SWI);
  wire last_wait = (cyc_left == `BIE_CYC_ONE);

  wire inc_accum_we;
  wire inc_reg_we;
  wire [7:0] inc_sum;
  wire inc_zero;

  bie_register_increment_instr u_register_increment_instr (
    .reg_val_i(instr_i.reg_val),
    .dest_i(instr_i.dest),
    .accum_we_o(inc_accum_we),
    .reg_we_o(inc_reg_we),
    .sum_o(inc_sum),
    .zero_o(inc_zero)
  );

  // enable and disable share one opcode field, so they never arrive together
  wire irq_on_or_hold = is_irq_on ? `BIE_IRQ_ON : global_irq_enable;
  assign next_global_irq_enable = is_irq_off ? `BIE_IRQ_OFF : irq_on_or_hold;

  // pc only moves with a load strobe; otherwise it keeps the last target for the fetch side
  wire [8:0] swi_or_hold = is_swi ? `BIE_SWI_VECTOR : pc;
  wire [8:0] jmpa_or_rest = is_jmpa ? jmpa_target : swi_or_hold;
  assign next_pc = is_jmp ? jmp_target : jmpa_or_rest;
  assign next_pc_load = is_pc_change;

  // push and vector load leave together; the stack sees pc+1 in the same cycle
  assign next_stack_push = is_swi;
  assign next_stack_data = is_swi ? ret_addr : stack_data;

  // only increment touches the zero flag; the other five ops leave the write-back flags alone
  assign next_wb = '{
    accum_we: is_inc && inc_accum_we,
    reg_we: is_inc && inc_reg_we,
    data: is_inc ? inc_sum : wb.data,
    zero_we: is_inc,
    zero: is_inc ? inc_zero : wb.zero
  };

  // multi-cycle ops hold off the next instruction; the count includes the take cycle
  always_comb begin
    next_state = state;
    next_cyc_left = cyc_left;
    unique case (state)
      BIE_ST_IDLE: begin
        if (is_branch) begin
          next_state = BIE_ST_WAIT;
          next_cyc_left = branch_wait;
        end else if (is_swi) begin
          next_state = BIE_ST_WAIT;
          next_cyc_left = swi_wait;
        end
      end
      BIE_ST_WAIT: begin
        next_cyc_left = bie_less_one(cyc_left);
        if (last_wait) begin
          next_state = BIE_ST_IDLE;
        end
      end
      default: begin
        // unused codes fall back to idle so a corrupt state cannot lock the block
        next_state = BIE_ST_IDLE;
        next_cyc_left = `BIE_CYC_NONE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state <= BIE_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cyc_left <= `BIE_CYC_NONE;
    end else begin
      cyc_left <= next_cyc_left;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      global_irq_enable <= `BIE_IRQ_EN_RESET;
    end else begin
      global_irq_enable <= next_global_irq_enable;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pc_load <= `BIE_PULSE_OFF;
    end else begin
      pc_load <= next_pc_load;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pc <= `BIE_PC_RESET;
    end else begin
      pc <= next_pc;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      stack_push <= `BIE_PULSE_OFF;
    end else begin
      stack_push <= next_stack_push;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      stack_data <= `BIE_PC_RESET;
    end else begin
      stack_data <= next_stack_data;
    end
  end

  // write-back strobes are single-cycle pulses; data and zero hold for late readers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wb <= '0;
    end else begin
      wb <= next_wb;
    end
  end

  assign instr_ready_o = (state == BIE_ST_IDLE);
  assign busy_o = (state != BIE_ST_IDLE);
  assign global_irq_enable_o = global_irq_enable;
  assign pc_load_o = pc_load;
  assign pc_o = pc;
  assign stack_push_o = stack_push;
  assign stack_data_o = stack_data;
  assign wb_o = wb;
endmodule : bie_exec

// *** tb/bie_exec_chk.sv ***
`timescale 1ns/1ps
module bie_chk
  import bie_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire bie_instr_t instr_i,
  input wire bie_ctx_t ctx_i,
  input wire logic [8:0] instr_pc_i,
  input wire logic instr_ready_o,
  input wire logic global_irq_enable_o,
  input wire logic pc_load_o,
  input wire logic [8:0] pc_o,
  input wire logic stack_push_o,
  input wire logic [8:0] stack_data_o,
  input wire bie_wb_t wb_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  wire take = instr_valid_i && instr_ready_o;
  sequence s_vec;
    pc_load_o && stack_push_o && !instr_ready_o && pc_o == 9'h001
      && stack_data_o == $past(instr_pc_i) + 9'h001;
  endsequence
  a_irq_off_clear: assert property (take && instr_i.op == BIE_OP_IRQ_OFF |=>
    !global_irq_enable_o && !wb_o.zero_we)
    else $error("disable bad");
  a_irq_on_set: assert property (take && instr_i.op == BIE_OP_IRQ_ON |=>
    global_irq_enable_o && !wb_o.zero_we)
    else $error("enable bad");
  a_jmp_target: assert property (take && instr_i.op == BIE_OP_JMP |=> pc_load_o && !instr_ready_o
    && pc_o == {$past(ctx_i.page_high_buffer[0]), $past(instr_i.addr[7:0])} ##1 instr_ready_o)
    else $error("direct branch bad");
  a_jmpa_target: assert property (take && instr_i.op == BIE_OP_JMPA |=> pc_load_o && !instr_ready_o
    && pc_o == {$past(ctx_i.table_high_pointer[0]), $past(ctx_i.accumulator)} ##1 instr_ready_o)
    else $error("indexed branch bad");
  a_register_increment_instr_result: assert property (take && instr_i.op == BIE_OP_INC |=> wb_o.zero_we
    && wb_o.data == $past(instr_i.reg_val) + 8'h01 && wb_o.reg_we == $past(instr_i.dest)
    && wb_o.accum_we == !$past(instr_i.dest) && wb_o.zero == (wb_o.data == 8'h00))
    else $error("increment bad");
  a_swi_push: assert property (take && instr_i.op == BIE_OP_SWI |=>
    s_vec ##1 !instr_ready_o ##1 instr_ready_o)
    else $error("soft interrupt bad");
endmodule : bie_chk

bind bie_exec bie_chk u_chk (.clk_sys_i, .rst_n_i, .instr_valid_i, .instr_i, .ctx_i, .instr_pc_i,
  .instr_ready_o, .global_irq_enable_o, .pc_load_o, .pc_o, .stack_push_o, .stack_data_o, .wb_o);

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  import bie_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic instr_valid_i = 1'b0;
  bie_instr_t instr_i = '0;
  bie_ctx_t ctx_i = '0;
  logic [8:0] instr_pc_i = '0;
  logic instr_ready_o, global_irq_enable_o, pc_load_o, stack_push_o, busy_o;
  logic [8:0] pc_o, stack_data_o;
  bie_wb_t wb_o;
  int n_errors = 0;
  int checks_done = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  bie_exec dut (.clk_sys_i, .rst_n_i, .instr_valid_i, .instr_i, .ctx_i, .instr_pc_i, .instr_ready_o,
    .global_irq_enable_o, .pc_load_o, .pc_o, .stack_push_o, .stack_data_o, .wb_o, .busy_o);
  task close_out;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task chk(input string nm, input logic [8:0] s, input logic [8:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  // waits for idle, then offers one instruction; returns 1 ns after the taking edge
  task go(input bie_op_t op, input logic [8:0] a, input logic [7:0] r, input logic d, input bie_ctx_t c);
    int k;
    k = 0;
    while (instr_ready_o !== 1'b1 && k < 8) begin
      @(posedge clk_sys_i);
      #1;
      k++;
    end
    if (instr_ready_o !== 1'b1) begin
      n_errors++;
      close_out();
    end
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b1;
    instr_i <= '{op, a, d, r};
    ctx_i <= c;
    instr_pc_i <= a;
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b0;
    #1;
  endtask : go
  task t_irq;
    go(BIE_OP_IRQ_ON, 9'h000, 8'h00, 1'b0, '0);
    chk("irq_en", global_irq_enable_o, 1'b1);
    chk("zero_we", wb_o.zero_we, 1'b0);
    go(BIE_OP_IRQ_OFF, 9'h000, 8'h00, 1'b0, '0);
    chk("irq_en", global_irq_enable_o, 1'b0);
    chk("zero_we", wb_o.zero_we, 1'b0);
  endtask : t_irq
  task t_jmp;
    go(BIE_OP_JMP, 9'h0a5, 8'h00, 1'b0, '{8'h00, 8'h01, 8'h00});
    chk("pc", pc_o, 9'h1a5);
    chk("ready", instr_ready_o, 1'b0);
    chk("busy", busy_o, 1'b1);
    // page bit comes from the buffer even when the address field has bit 8 set
    go(BIE_OP_JMP, 9'h15a, 8'h00, 1'b0, '{8'h00, 8'hfe, 8'h00});
    chk("pc", pc_o, 9'h05a);
    go(BIE_OP_JMPA, 9'h000, 8'h00, 1'b0, '{8'h34, 8'h00, 8'h01});
    chk("pc", pc_o, 9'h134);
    chk("pc_load", pc_load_o, 1'b1);
  endtask : t_jmp
  task t_inc;
    go(BIE_OP_INC, 9'h000, 8'hff, 1'b1, '0);
    chk("reg_we", wb_o.reg_we, 1'b1);
    chk("accum_we", wb_o.accum_we, 1'b0);
    chk("data", wb_o.data, 8'h00);
    chk("zero", wb_o.zero, 1'b1);
    go(BIE_OP_INC, 9'h000, 8'h7f, 1'b0, '0);
    chk("accum_we", wb_o.accum_we, 1'b1);
    chk("reg_we", wb_o.reg_we, 1'b0);
    chk("data", wb_o.data, 8'h80);
    chk("zero", wb_o.zero, 1'b0);
  endtask : t_inc
  task t_swi;
    go(BIE_OP_SWI, 9'h0a0, 8'h00, 1'b0, '0);
    chk("push", stack_push_o, 1'b1);
    chk("ret", stack_data_o, 9'h0a1);
    chk("pc", pc_o, 9'h001);
    chk("pc_load", pc_load_o, 1'b1);
    @(posedge clk_sys_i);
    #1;
    chk("ready", instr_ready_o, 1'b0);
    chk("busy", busy_o, 1'b1);
    chk("push", stack_push_o, 1'b0);
    chk("pc_load", pc_load_o, 1'b0);
    @(posedge clk_sys_i);
    #1;
    chk("ready", instr_ready_o, 1'b1);
    chk("busy", busy_o, 1'b0);
  endtask : t_swi
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_irq();
    t_jmp();
    t_inc();
    t_swi();
    close_out();
  end
endmodule : tb
